// file: hdl/radio_link_settings_commands.sv
`timescale 1ns/1ps
module radio_link_settings_commands #(
  parameter int unsigned BAUD9600_DIV       = radio_link_pkg::BAUD_DIV_9600_DEF,
  parameter int unsigned ACK_WAIT_LONG_CYC  = radio_link_pkg::ACK_WAIT_LONG_CYC_DEF,
  parameter int unsigned ACK_WAIT_SHORT_CYC = radio_link_pkg::ACK_WAIT_SHORT_CYC_DEF
) (
  input  wire logic                       clk_i,
  input  wire logic                       rstn_i,
  input  wire logic                       soft_reset_i,
  input  wire logic                       cmd_rx_i,
  input  wire radio_link_pkg::radio_evt_t radio_evt_i,
  output logic                            cmd_tx_o,
  output logic [7:0]                      tx_power_level_o,
  output logic [7:0]                      host_baud_code_o,
  output logic                            tx_attempt_o,
  output logic                            no_radio_ack_exception_o,
  output logic                            retry_busy_o
);
  import radio_link_pkg::*;

  // ==========================================================
  // Decoding helpers
  function automatic setting_sel_t decode_addr(input logic [7:0] a);
    setting_sel_t s;
    s = '0;
    s.hit = 1'b1;
    unique case (a)
      ADDR_TX_POWER_WORKING:        s = '{1'b1, 1'b1, IDX_POWER};
      ADDR_HOST_BAUD_WORKING:       s = '{1'b1, 1'b1, IDX_BAUD};
      ADDR_ADDRESS_SCHEME_WORKING:  s = '{1'b1, 1'b1, IDX_ADDR_SCHEME};
      ADDR_SEND_WAIT_LIMIT_WORKING: s = '{1'b1, 1'b1, IDX_SEND_WAIT};
      ADDR_RETRY_LIMIT_WORKING:     s = '{1'b1, 1'b1, IDX_RETRY};
      ADDR_TX_POWER_STORED:         s = '{1'b1, 1'b0, IDX_POWER};
      ADDR_HOST_BAUD_STORED:        s = '{1'b1, 1'b0, IDX_BAUD};
      ADDR_ADDRESS_SCHEME_STORED:   s = '{1'b1, 1'b0, IDX_ADDR_SCHEME};
      ADDR_SEND_WAIT_LIMIT_STORED:  s = '{1'b1, 1'b0, IDX_SEND_WAIT};
      ADDR_RETRY_LIMIT_STORED:      s = '{1'b1, 1'b0, IDX_RETRY};
      default:                      s = '0;
    endcase
    return s;
  endfunction

  function automatic logic [15:0] baud_div(input logic [7:0] code);
    unique case (code)
      BAUD_CODE_19200:  baud_div = BAUD_DIV_19200;
      BAUD_CODE_38400:  baud_div = BAUD_DIV_38400;
      BAUD_CODE_57600:  baud_div = BAUD_DIV_57600;
      BAUD_CODE_115200: baud_div = BAUD_DIV_115200;
      BAUD_CODE_10400:  baud_div = BAUD_DIV_10400;
      BAUD_CODE_31250:  baud_div = BAUD_DIV_31250;
      default:          baud_div = 16'(BAUD9600_DIV);
    endcase
  endfunction

  localparam logic [7:0] SET_RST [NSET] = '{TX_POWER_RST, HOST_BAUD_RST,
    ADDRESS_SCHEME_RST, SEND_WAIT_LIMIT_RST, RETRY_LIMIT_RST};

  logic [7:0]   work_q [NSET];
  logic [7:0]   store_q [NSET];
  logic         rx_s1_q, rx_s2_q, rx_s3_q, rx_lvl_q;
  logic         rx_busy_q, rx_valid_q;
  logic [15:0]  rx_cnt_q;
  logic [3:0]   rx_bit_q;
  logic [7:0]   rx_sh_q, rx_byte_q;
  logic         tx_busy_q, tx_done_q;
  logic [15:0]  tx_cnt_q;
  logic [3:0]   tx_bit_q;
  logic [8:0]   tx_sh_q;
  parse_state_t pst_q;
  setting_sel_t cmd_sel_q;
  logic [7:0]   cmd_val_q;
  logic [7:0]   resp_q [3];
  logic [1:0]   resp_len_q, resp_idx_q;
  logic         resp_active_q, pend_wr_q, apply_wr_q;
  retry_state_t rst_q;
  logic [7:0]   retry_left_q;
  logic [21:0]  wait_cnt_q;
  logic [15:0]  bit_div;
  logic [21:0]  wait_cyc;
  logic         tx_go;
  setting_sel_t rx_sel;

  assign bit_div = baud_div(work_q[IDX_BAUD]);
  assign tx_go   = resp_active_q && !tx_busy_q && (resp_idx_q != resp_len_q);
  assign rx_sel  = decode_addr(rx_byte_q);
  assign tx_power_level_o = work_q[IDX_POWER];
  assign host_baud_code_o = work_q[IDX_BAUD];

  // ==========================================================
  // Settings storage
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      for (int i = 0; i < NSET; i++) begin
        work_q[i]  <= SET_RST[i];
        store_q[i] <= SET_RST[i];
      end
    end else if (soft_reset_i) begin
      for (int i = 0; i < NSET; i++) begin
        work_q[i] <= store_q[i];
      end
    end else if (apply_wr_q) begin
      if (cmd_sel_q.vol) begin
        work_q[cmd_sel_q.idx] <= cmd_val_q;
      end else begin
        store_q[cmd_sel_q.idx] <= cmd_val_q;
      end
    end
  end

  // ==========================================================
  // Receive pin synchroniser and filter
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rx_s1_q  <= 1'b1;
      rx_s2_q  <= 1'b1;
      rx_s3_q  <= 1'b1;
      rx_lvl_q <= 1'b1;
    end else begin
      rx_s1_q <= cmd_rx_i;
      rx_s2_q <= rx_s1_q;
      rx_s3_q <= rx_s2_q;
      if (rx_s2_q == rx_s3_q) begin
        rx_lvl_q <= rx_s3_q;
      end
    end
  end

  // ==========================================================
  // Byte receiver
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rx_busy_q  <= 1'b0;
      rx_valid_q <= 1'b0;
      rx_cnt_q   <= 16'h0000;
      rx_bit_q   <= 4'h0;
      rx_sh_q    <= 8'h00;
      rx_byte_q  <= 8'h00;
    end else begin
      rx_valid_q <= 1'b0;
      if (!rx_busy_q) begin
        if (!rx_lvl_q) begin
          rx_busy_q <= 1'b1;
          rx_cnt_q  <= bit_div >> 1;
          rx_bit_q  <= 4'h0;
        end
      end else if (rx_cnt_q != 16'h0000) begin
        rx_cnt_q <= rx_cnt_q - 16'h0001;
      end else begin
        rx_cnt_q <= bit_div - 16'h0001;
        rx_bit_q <= rx_bit_q + 4'h1;
        if (rx_bit_q == 4'h0 && rx_lvl_q) begin
          rx_busy_q <= 1'b0;
        end else if (rx_bit_q == 4'h9) begin
          rx_busy_q  <= 1'b0;
          rx_valid_q <= rx_lvl_q;
          rx_byte_q  <= rx_sh_q;
        end else if (rx_bit_q != 4'h0) begin
          rx_sh_q <= {rx_lvl_q, rx_sh_q[7:1]};
        end
      end
    end
  end

  // ==========================================================
  // Command parser and answer sequencing
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      pst_q         <= P_IDLE;
      cmd_sel_q     <= '0;
      cmd_val_q     <= 8'h00;
      resp_q        <= '{8'h00, 8'h00, 8'h00};
      resp_len_q    <= 2'h0;
      resp_idx_q    <= 2'h0;
      resp_active_q <= 1'b0;
      pend_wr_q     <= 1'b0;
      apply_wr_q    <= 1'b0;
    end else begin
      apply_wr_q <= 1'b0;
      if (soft_reset_i) begin
        pst_q         <= P_IDLE;
        resp_active_q <= 1'b0;
        pend_wr_q     <= 1'b0;
      end else begin
        if (tx_go) begin
          resp_idx_q <= resp_idx_q + 2'h1;
        end
        if (tx_done_q && resp_active_q && resp_idx_q == resp_len_q) begin
          resp_active_q <= 1'b0;
          pend_wr_q     <= 1'b0;
          apply_wr_q    <= pend_wr_q;
        end
        if (rx_valid_q && !resp_active_q) begin
          unique case (pst_q)
            P_IDLE: begin
              if (rx_byte_q == HDR_BYTE) begin
                pst_q <= P_LEN;
              end
            end
            P_LEN: begin
              pst_q <= (rx_byte_q == LEN_BYTE) ? P_ADDR : P_IDLE;
            end
            P_ADDR: begin
              if (rx_byte_q == ESC_BYTE) begin
                pst_q <= P_RADDR;
              end else if (rx_sel.hit) begin
                cmd_sel_q <= rx_sel;
                pst_q     <= P_VALUE;
              end else begin
                pst_q <= P_IDLE;
              end
            end
            P_RADDR: begin
              pst_q <= P_IDLE;
              if (rx_sel.hit) begin
                resp_q[0]     <= ACK_BYTE;
                resp_q[1]     <= rx_byte_q;
                resp_q[2]     <= rx_sel.vol ? work_q[rx_sel.idx] : store_q[rx_sel.idx];
                resp_len_q    <= 2'h3;
                resp_idx_q    <= 2'h0;
                resp_active_q <= 1'b1;
              end
            end
            P_VALUE: begin
              pst_q         <= P_IDLE;
              cmd_val_q     <= rx_byte_q;
              resp_q[0]     <= ACK_BYTE;
              resp_len_q    <= 2'h1;
              resp_idx_q    <= 2'h0;
              resp_active_q <= 1'b1;
              pend_wr_q     <= 1'b1;
            end
          endcase
        end
      end
    end
  end

  // ==========================================================
  // Byte transmitter
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cmd_tx_o  <= 1'b1;
      tx_busy_q <= 1'b0;
      tx_done_q <= 1'b0;
      tx_cnt_q  <= 16'h0000;
      tx_bit_q  <= 4'h0;
      tx_sh_q   <= 9'h1ff;
    end else begin
      tx_done_q <= 1'b0;
      if (!tx_busy_q) begin
        cmd_tx_o <= 1'b1;
        if (tx_go) begin
          tx_busy_q <= 1'b1;
          cmd_tx_o  <= 1'b0;
          tx_sh_q   <= {1'b1, resp_q[resp_idx_q]};
          tx_cnt_q  <= bit_div - 16'h0001;
          tx_bit_q  <= 4'h0;
        end
      end else if (tx_cnt_q != 16'h0000) begin
        tx_cnt_q <= tx_cnt_q - 16'h0001;
      end else if (tx_bit_q == 4'h9) begin
        tx_busy_q <= 1'b0;
        tx_done_q <= 1'b1;
      end else begin
        cmd_tx_o <= tx_sh_q[0];
        tx_sh_q  <= {1'b1, tx_sh_q[8:1]};
        tx_bit_q <= tx_bit_q + 4'h1;
        tx_cnt_q <= bit_div - 16'h0001;
      end
    end
  end

  // ==========================================================
  // Radio acknowledgement retry sequencer
  always_comb begin
    unique case (work_q[IDX_BAUD])
      BAUD_CODE_38400, BAUD_CODE_57600, BAUD_CODE_115200:
        wait_cyc = 22'(ACK_WAIT_SHORT_CYC);
      default:
        wait_cyc = 22'(ACK_WAIT_LONG_CYC);
    endcase
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rst_q                    <= R_IDLE;
      retry_left_q             <= 8'h00;
      wait_cnt_q               <= 22'h000000;
      tx_attempt_o             <= 1'b0;
      no_radio_ack_exception_o <= 1'b0;
      retry_busy_o             <= 1'b0;
    end else begin
      tx_attempt_o             <= 1'b0;
      no_radio_ack_exception_o <= 1'b0;
      if (soft_reset_i) begin
        rst_q        <= R_IDLE;
        retry_busy_o <= 1'b0;
      end else begin
        unique case (rst_q)
          R_IDLE: begin
            if (radio_evt_i.start) begin
              rst_q        <= R_AIR;
              retry_left_q <= work_q[IDX_RETRY];
              tx_attempt_o <= 1'b1;
              retry_busy_o <= 1'b1;
            end
          end
          R_AIR: begin
            if (radio_evt_i.ack) begin
              rst_q        <= R_IDLE;
              retry_busy_o <= 1'b0;
            end else if (radio_evt_i.air_done) begin
              rst_q      <= R_WAIT;
              wait_cnt_q <= wait_cyc - 22'h000001;
            end
          end
          R_WAIT: begin
            if (radio_evt_i.ack) begin
              rst_q        <= R_IDLE;
              retry_busy_o <= 1'b0;
            end else if (wait_cnt_q != 22'h000000) begin
              wait_cnt_q <= wait_cnt_q - 22'h000001;
            end else if (retry_left_q == 8'h00) begin
              rst_q                    <= R_IDLE;
              retry_busy_o             <= 1'b0;
              no_radio_ack_exception_o <= 1'b1;
            end else begin
              retry_left_q <= retry_left_q - 8'h01;
              tx_attempt_o <= 1'b1;
              rst_q        <= R_AIR;
            end
          end
          default: begin
            rst_q        <= R_IDLE;
            retry_busy_o <= 1'b0;
          end
        endcase
      end
    end
  end

endmodule

// file: hdl/radio_link_pkg.sv
package radio_link_pkg;

  // ==========================================================
  // Clock and protocol bytes
  localparam int CLK_HZ = 40_000_000;
  localparam logic [7:0] HDR_BYTE = 8'hff;
  localparam logic [7:0] LEN_BYTE = 8'h02;
  localparam logic [7:0] ESC_BYTE = 8'hfe;
  localparam logic [7:0] ACK_BYTE = 8'h06;

  // ==========================================================
  // Setting slots and command addresses
  localparam int NSET = 5;
  localparam logic [2:0] IDX_POWER       = 3'h0;
  localparam logic [2:0] IDX_BAUD        = 3'h1;
  localparam logic [2:0] IDX_ADDR_SCHEME = 3'h2;
  localparam logic [2:0] IDX_SEND_WAIT   = 3'h3;
  localparam logic [2:0] IDX_RETRY       = 3'h4;
  localparam logic [7:0] ADDR_TX_POWER_STORED          = 8'h02;
  localparam logic [7:0] ADDR_HOST_BAUD_STORED         = 8'h03;
  localparam logic [7:0] ADDR_ADDRESS_SCHEME_STORED    = 8'h04;
  localparam logic [7:0] ADDR_SEND_WAIT_LIMIT_STORED   = 8'h05;
  localparam logic [7:0] ADDR_RETRY_LIMIT_STORED       = 8'h07;
  localparam logic [7:0] ADDR_TX_POWER_WORKING         = 8'h4d;
  localparam logic [7:0] ADDR_HOST_BAUD_WORKING        = 8'h4e;
  localparam logic [7:0] ADDR_ADDRESS_SCHEME_WORKING   = 8'h4f;
  localparam logic [7:0] ADDR_SEND_WAIT_LIMIT_WORKING  = 8'h50;
  localparam logic [7:0] ADDR_RETRY_LIMIT_WORKING      = 8'h52;

  // ==========================================================
  // Factory contents
  localparam logic [7:0] TX_POWER_RST        = 8'h03;
  localparam logic [7:0] HOST_BAUD_RST       = 8'h01;
  localparam logic [7:0] ADDRESS_SCHEME_RST  = 8'h00;
  localparam logic [7:0] SEND_WAIT_LIMIT_RST = 8'h00;
  localparam logic [7:0] RETRY_LIMIT_RST     = 8'h00;

  // ==========================================================
  // Baud codes, rates and bit periods
  localparam logic [7:0] BAUD_CODE_9600   = 8'h01;
  localparam logic [7:0] BAUD_CODE_19200  = 8'h02;
  localparam logic [7:0] BAUD_CODE_38400  = 8'h03;
  localparam logic [7:0] BAUD_CODE_57600  = 8'h04;
  localparam logic [7:0] BAUD_CODE_115200 = 8'h05;
  localparam logic [7:0] BAUD_CODE_10400  = 8'h06;
  localparam logic [7:0] BAUD_CODE_31250  = 8'h07;
  localparam int BAUD_DIV_9600_DEF = CLK_HZ / 9600;
  localparam logic [15:0] BAUD_DIV_19200  = 16'(CLK_HZ / 19200);
  localparam logic [15:0] BAUD_DIV_38400  = 16'(CLK_HZ / 38400);
  localparam logic [15:0] BAUD_DIV_57600  = 16'(CLK_HZ / 57600);
  localparam logic [15:0] BAUD_DIV_115200 = 16'(CLK_HZ / 115200);
  localparam logic [15:0] BAUD_DIV_10400  = 16'(CLK_HZ / 10400);
  localparam logic [15:0] BAUD_DIV_31250  = 16'(CLK_HZ / 31250);

  // ==========================================================
  // Acknowledgement wait
  localparam int ACK_WAIT_LONG_MS      = 50;
  localparam int ACK_WAIT_SHORT_MS     = 30;
  localparam int ACK_WAIT_LONG_CYC_DEF  = (CLK_HZ / 1000) * ACK_WAIT_LONG_MS;
  localparam int ACK_WAIT_SHORT_CYC_DEF = (CLK_HZ / 1000) * ACK_WAIT_SHORT_MS;

  // ==========================================================
  // Types
  typedef struct packed {
    logic       hit;
    logic       vol;
    logic [2:0] idx;
  } setting_sel_t;

  typedef struct packed {
    logic start;
    logic air_done;
    logic ack;
  } radio_evt_t;

  typedef enum logic [2:0] {
    P_IDLE  = 3'b000,
    P_LEN   = 3'b001,
    P_ADDR  = 3'b010,
    P_RADDR = 3'b011,
    P_VALUE = 3'b100
  } parse_state_t;

  typedef enum logic [1:0] {
    R_IDLE = 2'b00,
    R_AIR  = 2'b01,
    R_WAIT = 2'b10
  } retry_state_t;

endpackage

// file: bench/radio_link_checker.sv
`timescale 1ns/1ps
// ==========================================================
// Port checker for the settings command handler
module radio_link_checker (
  input wire logic                       clk_i,
  input wire logic                       rstn_i,
  input wire logic                       soft_reset_i,
  input wire radio_link_pkg::radio_evt_t radio_evt_i,
  input wire logic                       cmd_tx_o,
  input wire logic [7:0]                 tx_power_level_o,
  input wire logic [7:0]                 host_baud_code_o,
  input wire logic                       tx_attempt_o,
  input wire logic                       no_radio_ack_exception_o,
  input wire logic                       retry_busy_o
);
  import radio_link_pkg::*;
  default clocking cb @(posedge clk_i); endclocking
  a_reset_factory_codes: assert property ($rose(rstn_i) |-> cmd_tx_o &&
    tx_power_level_o == TX_POWER_RST && host_baud_code_o == HOST_BAUD_RST)
    else $error("factory codes missing after reset");
  a_start_gives_attempt: assert property (disable iff (!rstn_i)
    !retry_busy_o && radio_evt_i.start && !soft_reset_i |=> tx_attempt_o && retry_busy_o)
    else $error("start did not launch an attempt");
  a_idle_no_attempt: assert property (disable iff (!rstn_i)
    !retry_busy_o && !radio_evt_i.start |=> !tx_attempt_o)
    else $error("attempt without start");
  a_attempt_one_cycle: assert property (disable iff (!rstn_i)
    tx_attempt_o |-> retry_busy_o ##1 !tx_attempt_o)
    else $error("attempt pulse malformed");
  a_exception_ends_busy: assert property (disable iff (!rstn_i)
    no_radio_ack_exception_o |-> !retry_busy_o && $past(retry_busy_o))
    else $error("exception outside a retry sequence");
  a_ack_stops_retry: assert property (disable iff (!rstn_i)
    retry_busy_o && radio_evt_i.ack && !soft_reset_i |=> !retry_busy_o
    && !no_radio_ack_exception_o)
    else $error("ack did not end the sequence");
  a_power_after_answer: assert property (disable iff (!rstn_i)
    !$stable(tx_power_level_o) && !$past(soft_reset_i) |->
    $past(cmd_tx_o) && $past(cmd_tx_o, 4) && $past(cmd_tx_o, 8))
    else $error("power changed during an answer");
  a_baud_after_answer: assert property (disable iff (!rstn_i)
    !$stable(host_baud_code_o) && !$past(soft_reset_i) |->
    $past(cmd_tx_o) && $past(cmd_tx_o, 4) && $past(cmd_tx_o, 8))
    else $error("baud code changed during an answer");
endmodule

bind radio_link_settings_commands radio_link_checker i_radio_link_checker (
  .clk_i, .rstn_i, .soft_reset_i, .radio_evt_i, .cmd_tx_o, .tx_power_level_o,
  .host_baud_code_o, .tx_attempt_o, .no_radio_ack_exception_o, .retry_busy_o);

// file: bench/host_serial_model.sv
`timescale 1ns/1ps
// ==========================================================
// Host processor serial port, 8N1, LSB first, idle high
module host_serial_model (
  input  wire logic clk_i,
  input  wire logic line_i,
  output logic      line_o
);
  import radio_link_pkg::*;
  initial line_o = 1'b1;
  task automatic send_byte(input logic [7:0] b, input int div);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(posedge clk_i) line_o <= f[i];
      repeat (div - 1) @(posedge clk_i);
    end
  endtask
  // ==========================================================
  // Read is a = escape, b = address; write is a = address, b = value
  task automatic send_cmd(input logic [7:0] a, input logic [7:0] b, input int div);
    send_byte(HDR_BYTE, div);
    send_byte(LEN_BYTE, div);
    send_byte(a, div);
    send_byte(b, div);
  endtask
  task automatic get_byte(output logic [7:0] b, output logic ok, input int div);
    int n;
    n = 0;
    while (line_i !== 1'b0 && n < 40 * div) begin
      @(posedge clk_i);
      n++;
    end
    ok = (line_i === 1'b0);
    repeat (div / 2) @(posedge clk_i);
    for (int i = 0; i < 8; i++) begin
      repeat (div) @(posedge clk_i);
      b[i] = line_i;
    end
    repeat (div) @(posedge clk_i);
    ok = ok && (line_i === 1'b1);
  endtask
endmodule

// file: bench/test_radio_link_settings_commands.sv
`timescale 1ns/1ps
module test_radio_link_settings_commands;
  import radio_link_pkg::*;
  logic       clk_i, rstn_i, soft_reset_i, cmd_tx_o, tx_attempt_o, ok;
  logic       no_radio_ack_exception_o, retry_busy_o;
  wire logic  cmd_rx_i;
  radio_evt_t radio_evt_i;
  logic [7:0] tx_power_level_o, host_baud_code_o, b, lfsr_q;
  logic [7:0] vals [6];
  logic [7:0] addrs [6] = '{8'h02, 8'h4d, 8'h07, 8'h52, 8'h05, 8'h50};
  logic [7:0] codes [5] = '{8'h02, 8'h03, 8'h04, 8'h06, 8'h07};
  int         n_fail, comparisons, div;

  radio_link_settings_commands #(.BAUD9600_DIV(16), .ACK_WAIT_LONG_CYC(40),
    .ACK_WAIT_SHORT_CYC(24)) i_radio_link_settings_commands (.clk_i(clk_i),
    .rstn_i(rstn_i), .soft_reset_i(soft_reset_i), .cmd_rx_i(cmd_rx_i),
    .radio_evt_i(radio_evt_i), .cmd_tx_o(cmd_tx_o), .tx_power_level_o(tx_power_level_o),
    .host_baud_code_o(host_baud_code_o), .tx_attempt_o(tx_attempt_o),
    .no_radio_ack_exception_o(no_radio_ack_exception_o), .retry_busy_o(retry_busy_o));
  host_serial_model i_host_serial_model (.clk_i(clk_i), .line_i(cmd_tx_o), .line_o(cmd_rx_i));

  // ==========================================================
  // Expectations
  function automatic logic [7:0] lfsr_next(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  function automatic int div_of(input logic [7:0] c);
    case (c)
      BAUD_CODE_19200:  return int'(BAUD_DIV_19200);
      BAUD_CODE_38400:  return int'(BAUD_DIV_38400);
      BAUD_CODE_57600:  return int'(BAUD_DIV_57600);
      BAUD_CODE_115200: return int'(BAUD_DIV_115200);
      BAUD_CODE_10400:  return int'(BAUD_DIV_10400);
      BAUD_CODE_31250:  return int'(BAUD_DIV_31250);
      default:          return 16;
    endcase
  endfunction
  function automatic int wait_of(input logic [7:0] c);
    return (c inside {8'h03, 8'h04, 8'h05}) ? 24 : 40;
  endfunction

  // ==========================================================
  // Checking and transfers
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic rd(input logic [7:0] addr, input logic [7:0] exp);
    i_host_serial_model.send_cmd(ESC_BYTE, addr, div);
    i_host_serial_model.get_byte(b, ok, div);
    check(b, ACK_BYTE);
    i_host_serial_model.get_byte(b, ok, div);
    check(b, addr);
    i_host_serial_model.get_byte(b, ok, div);
    check(b, exp);
    check(8'(ok), 8'h01);
  endtask
  task automatic wr(input logic [7:0] addr, input logic [7:0] val);
    i_host_serial_model.send_cmd(addr, val, div);
    i_host_serial_model.get_byte(b, ok, div);
    check(b, ACK_BYTE);
    repeat (div) @(posedge clk_i);
  endtask
  task automatic soft_pulse;
    @(posedge clk_i) soft_reset_i <= 1'b1;
    @(posedge clk_i) soft_reset_i <= 1'b0;
    repeat (4) @(negedge clk_i);
  endtask
  task automatic radio_run(input int ack_on, input logic [7:0] limit, input int w);
    int cnt;
    @(posedge clk_i) radio_evt_i <= 3'b100;
    @(posedge clk_i) radio_evt_i <= 3'b000;
    @(negedge clk_i);
    check(8'(tx_attempt_o && retry_busy_o), 8'h01);
    for (int a = 0; a <= int'(limit); a++) begin
      repeat (3) @(posedge clk_i);
      radio_evt_i <= 3'b010;
      @(posedge clk_i) radio_evt_i <= (a == ack_on) ? 3'b001 : 3'b000;
      if (a == ack_on) begin
        @(posedge clk_i) radio_evt_i <= 3'b000;
        @(negedge clk_i);
        check(8'({retry_busy_o, no_radio_ack_exception_o}), 8'h00);
        return;
      end
      cnt = 0;
      while (tx_attempt_o !== 1'b1 && no_radio_ack_exception_o !== 1'b1 && cnt < 3 * w) begin
        @(negedge clk_i);
        cnt++;
      end
      check(8'(cnt >= w - 3 && cnt <= w + 3), 8'h01);
      check(8'(no_radio_ack_exception_o), 8'(a == int'(limit)));
    end
    check(8'(retry_busy_o), 8'h00);
  endtask
  task automatic final_report;
    if (n_fail == 0 && comparisons > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end
  initial begin
    repeat (95000) @(posedge clk_i);
    n_fail++;
    final_report;
  end

  // ==========================================================
  // Main sequence
  initial begin
    rstn_i = 1'b0;
    soft_reset_i = 1'b0;
    radio_evt_i = 3'b000;
    n_fail = 0;
    comparisons = 0;
    lfsr_q = 8'h48;
    div = 16;
    repeat (16) @(posedge clk_i);
    rstn_i <= 1'b1;
    repeat (4) @(negedge clk_i);
    check(tx_power_level_o, TX_POWER_RST);
    check(host_baud_code_o, HOST_BAUD_RST);
    rd(ADDR_TX_POWER_WORKING, TX_POWER_RST);
    rd(ADDR_HOST_BAUD_STORED, HOST_BAUD_RST);
    rd(ADDR_ADDRESS_SCHEME_WORKING, ADDRESS_SCHEME_RST);
    foreach (addrs[i]) begin
      lfsr_q = lfsr_next(lfsr_q);
      vals[i] = (i < 4) ? (lfsr_q & 8'h03) : lfsr_q;
      wr(addrs[i], vals[i]);
      rd(addrs[i], vals[i]);
      check(tx_power_level_o, (i > 0) ? vals[1] : TX_POWER_RST);
    end
    i_host_serial_model.send_cmd(ESC_BYTE, 8'h10, div);
    i_host_serial_model.get_byte(b, ok, div);
    check(8'(ok), 8'h00);
    radio_run(-1, vals[3], wait_of(BAUD_CODE_9600));
    radio_run(0, vals[3], wait_of(BAUD_CODE_9600));
    wr(ADDR_HOST_BAUD_STORED, BAUD_CODE_115200);
    check(host_baud_code_o, HOST_BAUD_RST);
    rd(ADDR_TX_POWER_WORKING, vals[1]);
    soft_pulse;
    check(host_baud_code_o, BAUD_CODE_115200);
    check(tx_power_level_o, vals[0]);
    div = div_of(BAUD_CODE_115200);
    rd(ADDR_HOST_BAUD_WORKING, BAUD_CODE_115200);
    radio_run(-1, vals[2], wait_of(BAUD_CODE_115200));
    wr(ADDR_HOST_BAUD_WORKING, BAUD_CODE_9600);
    div = div_of(BAUD_CODE_9600);
    rd(ADDR_HOST_BAUD_WORKING, BAUD_CODE_9600);
    wr(ADDR_HOST_BAUD_STORED, BAUD_CODE_9600);
    foreach (codes[i]) begin
      wr(ADDR_HOST_BAUD_WORKING, codes[i]);
      check(host_baud_code_o, codes[i]);
      soft_pulse;
    end
    final_report;
  end
endmodule
